/* File: dv/peia_event_irq_chk.sv */
// Checker for the event latch and request line; sees top-level ports only.
// Assumes the mask registers change only through writes on the register port.
`timescale 1ns/1ps
module peia_event_irq_chk #(
   parameter int LIMIT_CYCLES = peia_pkg::LIMIT_CYCLES
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic low_comparator,
   input wire logic charger_wake_input,
   input wire logic powerup_active,
   input wire logic [peia_pkg::MASK_FIRST_W-1:0] first_group_pending,
   input wire logic interrupt_request_line_n_out,
   input wire logic interrupt_request_line_n_oe_n
);
   import peia_pkg::*;
   logic [4:0] mask_a;
   logic [7:0] mask_b;
   logic [2:0] pu_hist;
   logic run_seen;
   wire line_n = interrupt_request_line_n_out;
   default clocking dc @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////////////////////////////////////////
   // Gate counts as open only once the line went low after power-up settled
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         mask_a <= 5'h00;
         mask_b <= 8'h00;
         pu_hist <= 3'h7;
         run_seen <= 1'b0;
      end else begin
         pu_hist <= {pu_hist[1:0], powerup_active};
         run_seen <= !powerup_active && pu_hist == 3'h0 && (run_seen || !line_n);
         if (reg_wr && reg_addr == OFS_MASK_FIRST)
            mask_a <= reg_wdata[4:0];
         if (reg_wr && reg_addr == OFS_MASK_SECOND)
            mask_b <= reg_wdata;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   sequence s_rise_open(logic src, logic m);
      run_seen && $rose(src) && !m;
   endsequence
   sequence s_line_low;
      ##[3:6] !line_n;
   endsequence
   property p_raise(logic src, logic m);
      s_rise_open(src, m) |-> s_line_low;
   endproperty
   chk_oe_follows:
      assert property (interrupt_request_line_n_oe_n == line_n)
      else $error("enable differs from line level");
   chk_rdata_idle:
      assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data outside read slot");
   chk_mask_a_back:
      assert property (reg_rd && reg_addr == OFS_MASK_FIRST |=> reg_rdata == {3'h0, mask_a})
      else $error("first mask readback wrong");
   chk_mask_b_back:
      assert property (reg_rd && reg_addr == OFS_MASK_SECOND |=> reg_rdata == mask_b)
      else $error("second mask readback wrong");
   chk_line_holds:
      assert property (!line_n && !reg_wr && !$past(reg_wr) && !powerup_active && first_group_pending == 5'h00
         && $past(first_group_pending) == 5'h00 |=> !line_n)
      else $error("line released without clearing write");
   chk_first_group:
      assert property (run_seen && !powerup_active && (first_group_pending & ~mask_a) != 5'h00 |=> !line_n)
      else $error("unmasked first group left line idle");
   chk_wake_line:
      assert property (p_raise(charger_wake_input, mask_b[BIT_CHARGER_WAKE]))
      else $error("wake edge did not drive line");
   chk_comp_line:
      assert property (p_raise(low_comparator, mask_b[BIT_LOW_COMPARATOR]))
      else $error("comparator edge did not drive line");
endmodule

bind peia_event_irq peia_event_irq_chk #(.LIMIT_CYCLES(LIMIT_CYCLES)) i_chk (
   .core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .low_comparator,
   .charger_wake_input, .powerup_active, .first_group_pending,
   .interrupt_request_line_n_out, .interrupt_request_line_n_oe_n
);

/* File: dv/peia_host_model.sv */
// Host processor model on the plain register port.
// Assumes callers enter its tasks just after a rising core_clk edge.
`timescale 1ns/1ps
module peia_host_model (
   input wire logic core_clk,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd,
   input wire logic [7:0] reg_rdata
);
   initial begin
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////
   // A spare edge after each strobe, so no strobe is set twice in one step
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      @(negedge core_clk);
      v = reg_rdata;
      @(posedge core_clk);
   endtask
   task automatic clear(input logic [7:0] a, output logic [7:0] v);
      rd(a, v);
      wr(a, v);
   endtask
endmodule

/* File: dv/pmic_event_irq_aggregator_tb_top.sv */
// Bench top: drives event pins and the host model, compares against an integer model.
// Assumes the design settles its line within six cycles of any cause.
`timescale 1ns/1ps
`define CHK(n, e, v) \
   begin \
      total_checks++; \
      if ((v) !== (e)) begin \
         fails++; \
         $display("BAD %s exp %h got %h", n, e, v); \
      end \
   end
module pmic_event_irq_aggregator_tb_top;
   import peia_pkg::*;
   localparam int LIM = 20;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
   logic reg_wr, reg_rd, line_out, line_oe_n;
   logic [7:0] src = 8'h00;
   logic [15:0] gi = 16'h0000;
   logic [4:0] llim = 5'h00;
   logic [4:0] fgp = 5'h00;
   logic [2:0] at = 3'h0;
   logic rmr = 1'b0;
   logic hs = 1'b0;
   logic pua = 1'b1;
   logic run = 1'b0;
   int fails = 0;
   int total_checks = 0;
   int seed = 32'hf937843b;
   int ev[3] = '{0, 0, 0};
   int m1 = 0;
   int m2 = 0;
   int r;
   int bits[$] = '{7, 6, 5, 4, 2, 1, 0};
   always #25 core_clk = ~core_clk;
   peia_host_model i_host (.core_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
   peia_event_irq #(.LIMIT_CYCLES(LIM)) i_dut (
      .core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .supply_below_upper(src[7]), .supply_monitor_threshold(src[6]), .dynamic_voltage_ramp(src[5]),
      .regulator_out_of_window(src[4]), .regulator_measure_ready(rmr), .linear_reg_limit(llim),
      .low_comparator(src[2]), .junction_hot(src[1]), .charger_wake_input(src[0]), .general_input(gi),
      .analog_threshold(at), .high_speed_two_wire_port(hs), .powerup_active(pua), .first_group_pending(fgp),
      .interrupt_request_line_n_out(line_out), .interrupt_request_line_n_oe_n(line_oe_n)
   );
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic exp_line();
      return !(run && ((ev[0] & ~m2) != 0 || ev[1] != 0 || ev[2] != 0 || (fgp & ~m1[4:0]) != 5'h00));
   endfunction
   task automatic line_chk();
      repeat (6) @(posedge core_clk);
      @(negedge core_clk);
      `CHK("line_out", exp_line(), line_out)
      `CHK("line_oe_n", exp_line(), line_oe_n)
      @(posedge core_clk);
   endtask
   task automatic reg_chk(input logic [7:0] a, input int e);
      i_host.rd(a, d);
      `CHK("reg_rdata", e[7:0], d)
   endtask
   task automatic clr(input int i);
      i_host.clear(OFS_SUPPLY_EVENTS + 8'(i), d);
      `CHK("event_reg", ev[i][7:0], d)
      ev[i] = ev[i] & ~int'(d);
      if (ev[0] == 0 && ev[1] == 0 && ev[2] == 0 && !pua)
         run = 1'b1;
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Whole sequence needs under two thousand cycles
   initial begin
      repeat (5000) @(posedge core_clk);
      fails++;
      complete_run();
   end
   initial begin
      repeat (3) @(posedge core_clk);
      rst_n <= 1'b1;
      src[1] <= 1'b1;
      ev[0] = 2;
      line_chk();
      pua <= 1'b0;
      src[1] <= 1'b0;
      line_chk();
      clr(0);
      $display("test powerup done");
      reg_chk(OFS_MASK_SECOND, 0);
      i_host.wr(OFS_MASK_FIRST, 8'hff);
      reg_chk(OFS_MASK_FIRST, 8'h1f);
      i_host.wr(OFS_MASK_SECOND, 8'h5a);
      reg_chk(OFS_MASK_SECOND, 8'h5a);
      reg_chk(8'h3f, 0);
      i_host.wr(OFS_MASK_FIRST, 8'h00);
      i_host.wr(OFS_MASK_SECOND, 8'h00);
      $display("test masks done");
      foreach (bits[k]) begin
         src[bits[k]] <= 1'b1;
         ev[0] |= (bits[k] == 5) ? 0 : (1 << bits[k]);
         line_chk();
         src[bits[k]] <= 1'b0;
         ev[0] |= (bits[k] == 5 || bits[k] == 6) ? (1 << bits[k]) : 0;
         line_chk();
         clr(0);
         line_chk();
      end
      i_host.wr(OFS_MONITOR_CONTROL, 8'h01);
      src[4] <= 1'b1;
      line_chk();
      rmr <= 1'b1;
      ev[0] = 16;
      line_chk();
      clr(0);
      src[4] <= 1'b0;
      rmr <= 1'b0;
      i_host.wr(OFS_MONITOR_CONTROL, 8'h00);
      $display("test supply sources done");
      // Short episode stays below the limit, long one passes it
      llim <= 5'b00100;
      repeat (LIM - 2) @(posedge core_clk);
      llim <= 5'b00000;
      line_chk();
      llim <= 5'b10000;
      repeat (LIM + 8) @(posedge core_clk);
      ev[0] = 8;
      clr(0);
      llim <= 5'b00000;
      $display("test current limit done");
      r = $random(seed);
      gi <= r[15:0];
      at <= r[18:16];
      hs <= 1'b1;
      ev[1] = r[7:0] | r[18:16];
      ev[2] = r[15:8] | 8'h40;
      line_chk();
      clr(1);
      line_chk();
      clr(2);
      gi[15:8] <= 8'hff;
      ev[2] = r[15:8] ^ 8'hff;
      line_chk();
      clr(2);
      i_host.wr(OFS_INPUT_POLARITY_HIGH, 8'h00);
      gi[15:8] <= r[31:24];
      ev[2] = r[31:24] ^ 8'hff;
      line_chk();
      clr(2);
      $display("test general inputs done");
      i_host.wr(OFS_MASK_SECOND, 8'hff);
      m2 = 255;
      src[0] <= 1'b1;
      ev[0] = 1;
      line_chk();
      clr(0);
      src[0] <= 1'b0;
      fgp <= 5'b00001;
      line_chk();
      i_host.wr(OFS_MASK_FIRST, 8'h01);
      m1 = 1;
      line_chk();
      fgp <= 5'b00000;
      i_host.wr(OFS_MASK_SECOND, 8'h00);
      m2 = 0;
      src[2:1] <= 2'b11;
      ev[0] = 6;
      line_chk();
      i_host.wr(OFS_SUPPLY_EVENTS, 8'h02);
      ev[0] = 4;
      line_chk();
      clr(0);
      src[2:1] <= 2'b00;
      $display("test mask and partial clear done");
      for (int k = 0; k < 3; k++) begin
         src[0] <= 1'b1;
         repeat (k) @(posedge core_clk);
         i_host.wr(OFS_SUPPLY_EVENTS, 8'hff);
         repeat (4) @(posedge core_clk);
         ev[0] = 1;
         clr(0);
         src[0] <= 1'b0;
         line_chk();
      end
      $display("test clear collision done");
      complete_run();
   end
endmodule

/* File: logic/peia_event_irq.sv */
// Event latching, masking and interrupt request line of the power manager.
// Assumes asynchronous source pins, a single 20 MHz clock and a host on the plain register port.
//
// Added by the designer: strobed register access.
`timescale 1ns/1ps

module peia_event_irq #(
   parameter int LIMIT_CYCLES = peia_pkg::LIMIT_CYCLES
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic supply_below_upper,
   input wire logic supply_monitor_threshold,
   input wire logic dynamic_voltage_ramp,
   input wire logic regulator_out_of_window,
   input wire logic regulator_measure_ready,
   input wire logic [peia_pkg::NUM_LINEAR_REGS-1:0] linear_reg_limit,
   input wire logic low_comparator,
   input wire logic junction_hot,
   input wire logic charger_wake_input,
   input wire logic [peia_pkg::NUM_INPUTS-1:0] general_input,
   input wire logic [peia_pkg::NUM_ANALOG-1:0] analog_threshold,
   input wire logic high_speed_two_wire_port,
   input wire logic powerup_active,
   input wire logic [peia_pkg::MASK_FIRST_W-1:0] first_group_pending,
   output logic interrupt_request_line_n_out,
   output logic interrupt_request_line_n_oe_n
);
   import peia_pkg::*;

   if (LIMIT_CYCLES < 1 || LIMIT_CYCLES >= (1 << LIMIT_CNT_W)) begin : g_bad_limit
      $error("LIMIT_CYCLES out of range for the limit counter");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers; logic reads the second stage and its one-cycle delayed copy pins_prev
   // Ten single pins plus the limit, input and analog groups; powerup_active must be the top bit
   localparam int SYNC_W = 10 + NUM_LINEAR_REGS + NUM_INPUTS + NUM_ANALOG;

   logic [SYNC_W-1:0] sync_meta;
   logic [SYNC_W-1:0] sync_pins;
   logic [SYNC_W-1:0] pins_prev;
   wire [SYNC_W-1:0] raw_pins = {powerup_active, high_speed_two_wire_port, analog_threshold,
      general_input, charger_wake_input, junction_hot, low_comparator, linear_reg_limit,
      regulator_measure_ready, regulator_out_of_window, dynamic_voltage_ramp,
      supply_monitor_threshold, supply_below_upper};

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         sync_meta <= '0;
         sync_pins <= '0;
         pins_prev <= '0;
      end else begin
         sync_meta <= raw_pins;
         sync_pins <= sync_meta;
         pins_prev <= sync_pins;
      end
   end

   // Field slices of the synchronised vector
   localparam int P_LIM = 5;
   localparam int P_CMP = P_LIM + NUM_LINEAR_REGS;
   localparam int P_GPI = P_CMP + 3;
   localparam int P_ADC = P_GPI + NUM_INPUTS;
   localparam int P_TWW = P_ADC + NUM_ANALOG;
   localparam int P_PWR = P_TWW + 1;

   wire [SYNC_W-1:0] rise = sync_pins & ~pins_prev;
   wire [SYNC_W-1:0] fall = ~sync_pins & pins_prev;
   wire [SYNC_W-1:0] change = sync_pins ^ pins_prev;
   wire [NUM_LINEAR_REGS-1:0] lim_level = sync_pins[P_LIM +: NUM_LINEAR_REGS];
   wire [NUM_INPUTS-1:0] gpi_rise = rise[P_GPI +: NUM_INPUTS];
   wire [NUM_INPUTS-1:0] gpi_fall = fall[P_GPI +: NUM_INPUTS];
   wire [NUM_ANALOG-1:0] adc_rise = rise[P_ADC +: NUM_ANALOG];
   wire powerup_level = sync_pins[P_PWR];

   ////////////////////////////////////////////////////////////////////////////
   // Software registers
   logic [7:0] mask_first;
   logic [7:0] mask_second;
   logic [7:0] polarity_low;
   logic [7:0] polarity_high;
   logic [7:0] monitor_control;
   logic [7:0] events [3];
   logic [7:0] held [3];

   wire wr_mask_first = reg_wr && reg_addr == OFS_MASK_FIRST;
   wire wr_mask_second = reg_wr && reg_addr == OFS_MASK_SECOND;
   wire wr_pol_low = reg_wr && reg_addr == OFS_INPUT_POLARITY_LOW;
   wire wr_pol_high = reg_wr && reg_addr == OFS_INPUT_POLARITY_HIGH;
   wire wr_monitor = reg_wr && reg_addr == OFS_MONITOR_CONTROL;
   wire [2:0] wr_events = {reg_wr && reg_addr == OFS_INPUT_EVENTS_HIGH,
      reg_wr && reg_addr == OFS_INPUT_EVENTS_LOW, reg_wr && reg_addr == OFS_SUPPLY_EVENTS};

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         mask_first <= RST_MASK_FIRST;
         mask_second <= RST_MASK_SECOND;
         polarity_low <= RST_POLARITY;
         polarity_high <= RST_POLARITY;
         monitor_control <= RST_MONITOR_CONTROL;
      end else begin
         if (wr_mask_first) begin
            mask_first <= {3'h0, reg_wdata[MASK_FIRST_W-1:0]};
         end
         if (wr_mask_second) begin
            mask_second <= reg_wdata;
         end
         if (wr_pol_low) begin
            polarity_low <= reg_wdata;
         end
         if (wr_pol_high) begin
            polarity_high <= reg_wdata;
         end
         if (wr_monitor) begin
            monitor_control <= {7'h00, reg_wdata[BIT_MONITOR_MODE]};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Current limit duration, one counter per regulator
   logic [NUM_LINEAR_REGS-1:0] lim_fire;

   for (genvar i = 0; i < NUM_LINEAR_REGS; i++) begin : g_limit
      logic [LIMIT_CNT_W-1:0] lim_cnt;
      localparam logic [LIMIT_CNT_W-1:0] LIM_END = LIMIT_CNT_W'(LIMIT_CYCLES);
      // Fires once when the limit has been held beyond the full time; saturates until release
      wire lim_reached = lim_level[i] && lim_cnt == LIM_END;
      wire [LIMIT_CNT_W-1:0] next_lim_cnt = !lim_level[i] ? '0 :
         (lim_cnt == LIM_END + LIMIT_CNT_W'(1) ? lim_cnt : lim_cnt + LIMIT_CNT_W'(1));
      assign lim_fire[i] = lim_reached;
      always_ff @(posedge core_clk or negedge rst_n) begin
         if (!rst_n) begin
            lim_cnt <= '0;
         end else begin
            lim_cnt <= next_lim_cnt;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Event sources for each event register
   wire mode_measure = monitor_control[BIT_MONITOR_MODE];
   logic [7:0] src [3];

   assign src[0][BIT_SUPPLY_WARN] = rise[0];
   assign src[0][BIT_SUPPLY_MONITOR] = change[1];
   assign src[0][BIT_RAMP_DONE] = fall[2];
   assign src[0][BIT_REGULATOR_WINDOW] = mode_measure ? rise[4] : rise[3];
   assign src[0][BIT_LINEAR_REG_OVERCURRENT] = |lim_fire;
   assign src[0][BIT_LOW_COMPARATOR] = rise[P_CMP];
   assign src[0][BIT_JUNCTION_HOT] = rise[P_CMP + 1];
   assign src[0][BIT_CHARGER_WAKE] = rise[P_CMP + 2];

   // Active state: polarity one means high level is active, so the entering edge counts
   wire [NUM_INPUTS-1:0] polarity = {polarity_high, polarity_low};
   wire [NUM_INPUTS-1:0] gpi_event = (gpi_rise & polarity) | (gpi_fall & ~polarity);

   assign src[1] = gpi_event[7:0] | {5'h00, adc_rise};
   assign src[2] = gpi_event[15:8] | (8'(rise[P_TWW]) << BIT_TWO_WIRE_ADDRESSED);

   ////////////////////////////////////////////////////////////////////////////
   // Sticky event registers with write-one-to-clear
   for (genvar r = 0; r < 3; r++) begin : g_event
      // Arrivals during a clearing write wait one cycle so the clear cannot swallow them
      wire [7:0] clear_bits = wr_events[r] ? reg_wdata : 8'h00;
      wire [7:0] posted = wr_events[r] ? 8'h00 : (held[r] | src[r]);
      wire [7:0] next_held = wr_events[r] ? (held[r] | src[r]) : 8'h00;
      wire [7:0] next_events = (events[r] & ~clear_bits) | posted;
      always_ff @(posedge core_clk or negedge rst_n) begin
         if (!rst_n) begin
            events[r] <= RST_EVENTS;
            held[r] <= RST_EVENTS;
         end else begin
            events[r] <= next_events;
            held[r] <= next_held;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Power-up gate and interrupt request line
   wire any_event = |events[0] || |events[1] || |events[2] || |held[0] || |held[1] || |held[2];
   // Masks touch only the line; the latched bits above ignore them
   wire unmasked = |(events[0] & ~mask_second) || |events[1] || |events[2] ||
      |(first_group_pending & ~mask_first[MASK_FIRST_W-1:0]);

   peia_gate_t gate;
   peia_gate_t next_gate;

   always_comb begin
      next_gate = gate;
      case (gate)
         PEIA_HOLD: begin
            if (!powerup_level && !any_event) begin
               next_gate = PEIA_RUN;
            end
         end
         PEIA_RUN: begin
            if (powerup_level) begin
               next_gate = PEIA_HOLD;
            end
         end
         default: begin
            next_gate = PEIA_HOLD;
         end
      endcase
   end

   wire next_line_low = gate == PEIA_RUN && unmasked;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         gate <= PEIA_HOLD;
         interrupt_request_line_n_out <= 1'b1;
         interrupt_request_line_n_oe_n <= 1'b1;
      end else begin
         gate <= next_gate;
         interrupt_request_line_n_out <= !next_line_low;
         interrupt_request_line_n_oe_n <= !next_line_low;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read data, one cycle after the strobe; unmapped offsets read zero
   wire [7:0] status_word = {6'h00, gate == PEIA_HOLD, !interrupt_request_line_n_out};
   wire [7:0] read_sel = (reg_addr == OFS_SUPPLY_EVENTS) ? events[0] :
      (reg_addr == OFS_INPUT_EVENTS_LOW) ? events[1] :
      (reg_addr == OFS_INPUT_EVENTS_HIGH) ? events[2] :
      (reg_addr == OFS_MASK_FIRST) ? mask_first :
      (reg_addr == OFS_MASK_SECOND) ? mask_second :
      (reg_addr == OFS_INPUT_POLARITY_LOW) ? polarity_low :
      (reg_addr == OFS_INPUT_POLARITY_HIGH) ? polarity_high :
      (reg_addr == OFS_MONITOR_CONTROL) ? monitor_control :
      (reg_addr == OFS_BLOCK_STATUS) ? status_word : 8'h00;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
      end else begin
         reg_rdata <= reg_rd ? read_sel : 8'h00;
      end
   end
endmodule

/* File: logic/peia_pkg.sv */
// Package for the event latch and interrupt request block.
// Assumes one 20 MHz core clock and an 8-bit register port.
package peia_pkg;
   ////////////////////////////////////////////////////////////////////////////
   // Register offsets
   localparam logic [7:0] OFS_SUPPLY_EVENTS = 8'h07;
   localparam logic [7:0] OFS_INPUT_EVENTS_LOW = 8'h08;
   localparam logic [7:0] OFS_INPUT_EVENTS_HIGH = 8'h09;
   localparam logic [7:0] OFS_MASK_FIRST = 8'h0a;
   localparam logic [7:0] OFS_MASK_SECOND = 8'h0b;
   localparam logic [7:0] OFS_INPUT_POLARITY_LOW = 8'h20;
   localparam logic [7:0] OFS_INPUT_POLARITY_HIGH = 8'h21;
   localparam logic [7:0] OFS_MONITOR_CONTROL = 8'h22;
   localparam logic [7:0] OFS_BLOCK_STATUS = 8'h23;

   ////////////////////////////////////////////////////////////////////////////
   // Field positions in the event and monitor control registers, and the first mask width
   localparam int BIT_SUPPLY_WARN = 7;
   localparam int BIT_SUPPLY_MONITOR = 6;
   localparam int BIT_RAMP_DONE = 5;
   localparam int BIT_REGULATOR_WINDOW = 4;
   localparam int BIT_LINEAR_REG_OVERCURRENT = 3;
   localparam int BIT_LOW_COMPARATOR = 2;
   localparam int BIT_JUNCTION_HOT = 1;
   localparam int BIT_CHARGER_WAKE = 0;
   localparam int BIT_TWO_WIRE_ADDRESSED = 6;
   localparam int BIT_MONITOR_MODE = 0;
   localparam int MASK_FIRST_W = 5;

   ////////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [7:0] RST_EVENTS = 8'h00;
   localparam logic [7:0] RST_MASK_FIRST = 8'h00;
   localparam logic [7:0] RST_MASK_SECOND = 8'h00;
   localparam logic [7:0] RST_POLARITY = 8'hff;
   localparam logic [7:0] RST_MONITOR_CONTROL = 8'h00;

   ////////////////////////////////////////////////////////////////////////////
   // Timing
   localparam longint CLK_HZ = 20000000;
   localparam longint LIMIT_TIME_MS = 10;
   localparam int LIMIT_CYCLES = int'((LIMIT_TIME_MS * CLK_HZ) / 1000);
   localparam int LIMIT_CNT_W = 18;
   localparam int NUM_LINEAR_REGS = 5;
   localparam int NUM_INPUTS = 16;
   localparam int NUM_ANALOG = 3;

   ////////////////////////////////////////////////////////////////////////////
   // Power-up gate states
   typedef enum logic [1:0] {
      PEIA_HOLD = 2'b01,
      PEIA_RUN = 2'b10
   } peia_gate_t;
endpackage
